//--- src/cpl_pkg.sv
// Purpose: Shared constants for the copper link feature block
// Assumes: 16-bit management registers at 5-bit word addresses
// Notes:   Offsets and field positions are referenced by the design
package cpl_pkg;
   // Register word addresses
   localparam logic [4:0] A_CTRL = 5'h00;
   localparam logic [4:0] A_STAT = 5'h01;
   localparam logic [4:0] A_BYP  = 5'h02;
   localparam logic [4:0] A_AUX  = 5'h03;
   localparam logic [4:0] A_EXTM = 5'h04;
   localparam logic [4:0] A_EEE  = 5'h05;
   localparam logic [4:0] A_EXT3 = 5'h06;
   localparam logic [4:0] A_EXT4 = 5'h07;
   localparam logic [4:0] A_IMSK = 5'h08;
   localparam logic [4:0] A_ISTA = 5'h09;
   localparam logic [4:0] A_WCFG = 5'h0A;
   localparam logic [4:0] A_MAC0 = 5'h0B;
   localparam logic [4:0] A_MAC1 = 5'h0C;
   localparam logic [4:0] A_MAC2 = 5'h0D;
   localparam logic [4:0] A_PWD0 = 5'h0E;
   localparam logic [4:0] A_PWD1 = 5'h0F;
   localparam logic [4:0] A_PWD2 = 5'h10;
   // Field positions
   localparam int B_SPD_MSB  = 6;
   localparam int B_DUPLEX   = 8;
   localparam int B_ANEG     = 12;
   localparam int B_SPD_LSB  = 13;
   localparam int B_LINK     = 2;
   localparam int B_POL_DIS  = 4;
   localparam int B_XO_DIS   = 5;
   localparam int B_FSX_DIS  = 7;
   localparam int B_AUX_POL  = 8;
   localparam int B_AUX_CD   = 12;
   localparam int B_AUX_XO   = 13;
   localparam int B_MXO      = 2;
   localparam int B_LPI_EN   = 0;
   localparam int B_LOWAMP   = 4;
   localparam int B_GIGTEST  = 5;
   localparam int B_DS_STAT  = 1;
   localparam int B_DS_CFG   = 2;
   localparam int B_DS_EN    = 4;
   localparam int B_PD_RES   = 13;
   localparam int B_PD_EN    = 15;
   localparam int B_WAKE     = 6;
   localparam int B_PWD_EN   = 5;
   // Reset values
   localparam logic [15:0] R_CTRL = 16'h1040;
   localparam logic        R_LPI  = 1'h1;
   localparam logic        R_DSEN = 1'h1;
   // Speed codes and detection results
   localparam logic [1:0] SPD_10   = 2'h0;
   localparam logic [1:0] SPD_100  = 2'h1;
   localparam logic [1:0] SPD_1000 = 2'h2;
   localparam logic [1:0] PD_SRCH  = 2'h0;
   localparam logic [1:0] PD_LOOP  = 2'h1;
   localparam logic [1:0] PD_NONE  = 2'h2;
   // Timing and counts
   localparam int         CLK_MHZ    = 50;
   localparam int         PD_WAIT_US = 1000;
   localparam logic [2:0] DS_BASE    = 3'h2;
   localparam logic [2:0] SYNC_FF    = 3'h6;
   localparam logic [2:0] LAST_POS   = 3'h5;
   localparam logic [3:0] LAST_REP   = 4'hF;
   localparam logic [7:0] BYTE_FF    = 8'hFF;
   typedef enum logic [1:0] {PD_IDLE, PD_RUN, PD_POWER, PD_NORMAL} cpl_pd_t;
   typedef enum logic [1:0] {MP_SYNC, MP_MAC, MP_PWD} cpl_mp_t;
endpackage : cpl_pkg

//--- src/cpl_link_features.sv
// Purpose: Control and status of copper link features
// Assumes: Line-side detection and negotiation cores outside
// Notes:   Link and loopback levels come from pins and are filtered
// What this block does
// - Forced gigabit test mode without role setup
// - Auto crossover detect at all speeds
// - Polarity fix on each pair independently
// - Crossover and polarity fix on after reset
// - Crossover and polarity results in aux status
// - Crossover detect in forced 10/100 speed
// - Four pair mappings supported
// - Manual field forces straight or crossed
// - Downshift after configured failed gigabit attempts
// - Gigabit partner ends downshift without reset
// - Downshift enable, count, status in ext three
// - Low power idle in 100 and 1000
// - Low amplitude ten mode bit
// - Wake detect enabled by mask, pending status
// - Wake match drives interrupt output
// - Own wake config, password, station address
// - Send special pulses, result 00 searching
// - Looped pulses give result 01
// - Timeout gives 10, disables detect, negotiates
// - Link loss re-enters powered device detection
// - Forced speed and duplex from control
`timescale 1ns/1ps
`default_nettype none
module cpl_link_features
   import cpl_pkg::*;
#(
   parameter int P_PD_WAIT_US  = PD_WAIT_US,
   parameter int P_PD_WAIT_CYC = P_PD_WAIT_US * CLK_MHZ
)(
   input  wire logic        i_clock,
   input  wire logic        i_nrst,
   input  wire logic [4:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [15:0] o_rdata,
   input  wire logic        i_link_up,
   input  wire logic [1:0]  i_an_speed,
   input  wire logic        i_an_duplex,
   input  wire logic        i_mdi_crossed,
   input  wire logic        i_mdi_cd_swap,
   input  wire logic [3:0]  i_pol_inverted,
   input  wire logic        i_gig_fail,
   input  wire logic        i_partner_gig,
   input  wire logic        i_flp_looped,
   input  wire logic        i_rx_start,
   input  wire logic        i_rx_valid,
   input  wire logic [7:0]  i_rx_data,
   output logic             o_crossed,
   output logic             o_cd_swap,
   output logic      [3:0]  o_pol_fix,
   output logic      [1:0]  o_speed,
   output logic             o_full_duplex,
   output logic             o_autoneg_run,
   output logic             o_adv_gig,
   output logic             o_gig_test,
   output logic             o_lpi_allow,
   output logic             o_low_amp_ten,
   output logic             o_pd_flp_send,
   output logic             o_wake
);
   localparam int TW = $clog2(P_PD_WAIT_CYC + 1);
   localparam logic [TW-1:0] PD_LOAD = TW'(P_PD_WAIT_CYC);

   typedef struct packed {
      logic [15:0]   ctrl;
      logic          fsx_dis;
      logic          xo_dis;
      logic          pol_dis;
      logic [1:0]    mxo;
      logic          lpi_en;
      logic          lowamp;
      logic          gigtest;
      logic          ds_en;
      logic [1:0]    ds_cfg;
      logic          ds_stat;
      logic [2:0]    ds_cnt;
      logic          pd_en;
      logic [1:0]    pd_res;
      cpl_pd_t       pd_st;
      logic [TW-1:0] pd_tmr;
      logic          wake_msk;
      logic          wake_pend;
      logic          pwd_en;
      logic [47:0]   mac;
      logic [47:0]   pwd;
      logic [2:0]    link_s;
      logic [2:0]    lb_s;
      logic          link_f;
      logic          lb_f;
      cpl_mp_t       mp;
      logic [2:0]    ff_cnt;
      logic [2:0]    pos;
      logic [3:0]    rep;
      logic          xo;
      logic          cd;
      logic [3:0]    pol;
      logic [1:0]    spd;
      logic          dup;
      logic          gig_o;
      logic [15:0]   rdata;
   } cpl_state_t;

   cpl_state_t q, d;
   logic [1:0] rst_q;
   logic       rst_n;
   logic       mp_hit;
   logic       xo_auto;
   logic [1:0] fspd;

   // Byte i of a 48-bit address, first byte on the wire is the top one
   function automatic logic [7:0] byte_at(input logic [47:0] v, input logic [2:0] i);
      byte_at = v[47 - 8*i -: 8];
   endfunction : byte_at

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         rst_q <= 2'h0;
      else
         rst_q <= {rst_q[0], 1'b1};
   end
   assign rst_n = rst_q[1];

   assign fspd    = {q.ctrl[B_SPD_MSB], q.ctrl[B_SPD_LSB]};
   // Auto detection runs with negotiation, or forced 10/100 if allowed
   assign xo_auto = !q.xo_dis && (q.ctrl[B_ANEG] || !q.fsx_dis);

   always_comb
   begin
      d      = q;
      mp_hit = 1'b0;
      // Pin filter: a change counts once stages two and three agree
      d.link_s = {q.link_s[1:0], i_link_up};
      d.lb_s   = {q.lb_s[1:0], i_flp_looped};
      if (q.link_s[2] == q.link_s[1])
         d.link_f = q.link_s[2];
      if (q.lb_s[2] == q.lb_s[1])
         d.lb_f = q.lb_s[2];

      // Wiring: manual field wins, else auto result, else straight
      if (q.mxo[1])
         d.xo = q.mxo[0];
      else if (xo_auto)
         d.xo = i_mdi_crossed;
      else
         d.xo = 1'b0;
      // C/D swap covers the two extra mappings of the four
      d.cd  = xo_auto && !q.mxo[1] && i_mdi_cd_swap;
      d.pol = q.pol_dis ? 4'h0 : i_pol_inverted;

      // Resolved speed and duplex
      d.spd   = q.ctrl[B_ANEG] ? i_an_speed : fspd;
      d.dup   = q.ctrl[B_ANEG] ? i_an_duplex : q.ctrl[B_DUPLEX];
      d.gig_o = q.gigtest && !q.ctrl[B_ANEG] && fspd == SPD_1000;

      // Downshift: count failures, a gigabit partner undoes it
      if (i_partner_gig)
      begin
         d.ds_stat = 1'b0;
         d.ds_cnt  = 3'h0;
      end
      else if (q.ds_en && !q.ds_stat && i_gig_fail)
      begin
         if (q.ds_cnt + 3'h1 >= 3'(q.ds_cfg) + DS_BASE)
         begin
            d.ds_stat = 1'b1;
            d.ds_cnt  = 3'h0;
         end
         else
            d.ds_cnt = q.ds_cnt + 3'h1;
      end

      // Powered device detection sequence
      unique case (q.pd_st)
         PD_IDLE:
            if (q.pd_en && q.ctrl[B_ANEG])
            begin
               d.pd_st  = PD_RUN;
               d.pd_res = PD_SRCH;
               d.pd_tmr = PD_LOAD;
            end
         PD_RUN:
            if (q.lb_f)
            begin
               d.pd_st  = PD_POWER;
               d.pd_res = PD_LOOP;
            end
            else if (q.pd_tmr == '0)
            begin
               d.pd_st  = PD_NORMAL;
               d.pd_res = PD_NONE;
               d.pd_en  = 1'b0;
            end
            else
               d.pd_tmr = q.pd_tmr - TW'(1);
         PD_POWER:
            if (q.link_f)
               d.pd_st = PD_NORMAL;
         PD_NORMAL:
            // Only a link that was up and then fell restarts detection
            if (q.link_f && !q.link_s[2] && !q.link_s[1])
            begin
               d.pd_st  = PD_RUN;
               d.pd_en  = 1'b1;
               d.pd_res = PD_SRCH;
               d.pd_tmr = PD_LOAD;
            end
      endcase

      // Magic packet: six FF bytes, address sixteen times, password
      if (i_rx_start)
      begin
         d.mp     = MP_SYNC;
         d.ff_cnt = 3'h0;
      end
      else if (i_rx_valid && q.link_f)
      begin
         unique case (q.mp)
            MP_SYNC:
               if (q.ff_cnt == SYNC_FF && i_rx_data == byte_at(q.mac, 3'h0))
               begin
                  d.mp  = MP_MAC;
                  d.pos = 3'h1;
                  d.rep = 4'h0;
               end
               else if (i_rx_data == BYTE_FF)
                  d.ff_cnt = (q.ff_cnt == SYNC_FF) ? SYNC_FF : q.ff_cnt + 3'h1;
               else
                  d.ff_cnt = 3'h0;
            MP_MAC:
               if (i_rx_data != byte_at(q.mac, q.pos))
               begin
                  d.mp     = MP_SYNC;
                  d.ff_cnt = (i_rx_data == BYTE_FF) ? 3'h1 : 3'h0;
               end
               else if (q.pos != LAST_POS)
                  d.pos = q.pos + 3'h1;
               else if (q.rep != LAST_REP)
               begin
                  d.pos = 3'h0;
                  d.rep = q.rep + 4'h1;
               end
               else
               begin
                  d.pos    = 3'h0;
                  d.mp     = q.pwd_en ? MP_PWD : MP_SYNC;
                  d.ff_cnt = 3'h0;
                  mp_hit   = !q.pwd_en;
               end
            MP_PWD:
            begin
               d.pos = q.pos + 3'h1;
               if (i_rx_data != byte_at(q.pwd, q.pos) || q.pos == LAST_POS)
               begin
                  d.mp     = MP_SYNC;
                  d.ff_cnt = 3'h0;
                  mp_hit   = i_rx_data == byte_at(q.pwd, q.pos);
               end
            end
            default:
               d.mp = MP_SYNC;
         endcase
      end

      // Register writes; hardware-owned bits are not written here
      if (i_wr)
      begin
         unique case (i_addr)
            A_CTRL: d.ctrl = i_wdata;
            A_BYP:
            begin
               d.fsx_dis = i_wdata[B_FSX_DIS];
               d.xo_dis  = i_wdata[B_XO_DIS];
               d.pol_dis = i_wdata[B_POL_DIS];
            end
            A_EXTM: d.mxo = i_wdata[B_MXO +: 2];
            A_EEE:
            begin
               d.lpi_en  = i_wdata[B_LPI_EN];
               d.lowamp  = i_wdata[B_LOWAMP];
               d.gigtest = i_wdata[B_GIGTEST];
            end
            A_EXT3:
            begin
               d.ds_en  = i_wdata[B_DS_EN];
               d.ds_cfg = i_wdata[B_DS_CFG +: 2];
            end
            A_EXT4:
            begin
               // Clearing the enable abandons detection
               d.pd_en = i_wdata[B_PD_EN];
               if (!i_wdata[B_PD_EN])
                  d.pd_st = PD_IDLE;
            end
            A_IMSK: d.wake_msk = i_wdata[B_WAKE];
            A_WCFG: d.pwd_en = i_wdata[B_PWD_EN];
            A_MAC0: d.mac[47:32] = i_wdata;
            A_MAC1: d.mac[31:16] = i_wdata;
            A_MAC2: d.mac[15:0] = i_wdata;
            A_PWD0: d.pwd[47:32] = i_wdata;
            A_PWD1: d.pwd[31:16] = i_wdata;
            A_PWD2: d.pwd[15:0] = i_wdata;
            default: ;
         endcase
      end

      // Reads: data valid the next cycle only, unmapped reads zero
      d.rdata = 16'h0000;
      if (i_rd)
      begin
         unique case (i_addr)
            A_CTRL: d.rdata = q.ctrl;
            A_STAT: d.rdata[B_LINK] = q.link_f;
            A_BYP:
            begin
               d.rdata[B_FSX_DIS] = q.fsx_dis;
               d.rdata[B_XO_DIS]  = q.xo_dis;
               d.rdata[B_POL_DIS] = q.pol_dis;
            end
            A_AUX:
            begin
               d.rdata[B_AUX_XO]       = q.xo;
               d.rdata[B_AUX_CD]       = q.cd;
               d.rdata[B_AUX_POL +: 4] = q.pol;
            end
            A_EXTM: d.rdata[B_MXO +: 2] = q.mxo;
            A_EEE:
            begin
               d.rdata[B_LPI_EN]  = q.lpi_en;
               d.rdata[B_LOWAMP]  = q.lowamp;
               d.rdata[B_GIGTEST] = q.gigtest;
            end
            A_EXT3:
            begin
               d.rdata[B_DS_EN]      = q.ds_en;
               d.rdata[B_DS_CFG +: 2] = q.ds_cfg;
               d.rdata[B_DS_STAT]    = q.ds_stat;
            end
            A_EXT4:
            begin
               d.rdata[B_PD_EN]       = q.pd_en;
               d.rdata[B_PD_RES +: 2] = q.pd_res;
            end
            A_IMSK: d.rdata[B_WAKE] = q.wake_msk;
            A_ISTA: d.rdata[B_WAKE] = q.wake_pend;
            A_WCFG: d.rdata[B_PWD_EN] = q.pwd_en;
            A_MAC0: d.rdata = q.mac[47:32];
            A_MAC1: d.rdata = q.mac[31:16];
            A_MAC2: d.rdata = q.mac[15:0];
            A_PWD0: d.rdata = q.pwd[47:32];
            A_PWD1: d.rdata = q.pwd[31:16];
            A_PWD2: d.rdata = q.pwd[15:0];
            default: d.rdata = 16'h0000;
         endcase
      end

      // Pending clears on read, but a new match in that cycle wins
      if (i_rd && i_addr == A_ISTA)
         d.wake_pend = 1'b0;
      if (mp_hit && q.wake_msk)
         d.wake_pend = 1'b1;
   end

   always_ff @(posedge i_clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q        <= '0;
         q.ctrl   <= R_CTRL;
         q.lpi_en <= R_LPI;
         q.ds_en  <= R_DSEN;
         q.pd_st  <= PD_IDLE;
         q.mp     <= MP_SYNC;
      end
      else
         q <= d;
   end

   assign o_rdata       = q.rdata;
   assign o_crossed     = q.xo;
   assign o_cd_swap     = q.cd;
   assign o_pol_fix     = q.pol;
   assign o_speed       = q.spd;
   assign o_full_duplex = q.dup;
   assign o_gig_test    = q.gig_o;
   assign o_adv_gig     = !q.ds_stat;
   // Negotiation pauses only while pulses are being sent
   assign o_autoneg_run = q.ctrl[B_ANEG] && q.pd_st != PD_RUN;
   assign o_pd_flp_send = q.pd_st == PD_RUN;
   // Idle cycling is only offered on a 100 or 1000 link
   assign o_lpi_allow   = q.lpi_en && q.link_f && q.spd != SPD_10;
   assign o_low_amp_ten = q.lowamp;
   assign o_wake        = q.wake_pend && q.wake_msk;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!rst_n);

   property p_gig_test;
      (q.gigtest && !q.ctrl[B_ANEG] && fspd == SPD_1000) |=> o_gig_test;
   endproperty
   a_gig_test: assert property (p_gig_test) else $error("test mode not entered");
   property p_mxo_straight;
      (q.mxo == 2'h2) |=> !o_crossed;
   endproperty
   a_mxo_straight: assert property (p_mxo_straight) else $error("not straight");
   property p_mxo_cross;
      (q.mxo == 2'h3) |=> o_crossed && !o_cd_swap;
   endproperty
   a_mxo_cross: assert property (p_mxo_cross) else $error("not crossed");
   property p_pol_off;
      q.pol_dis |=> o_pol_fix == 4'h0;
   endproperty
   a_pol_off: assert property (p_pol_off) else $error("polarity fix while off");
   property p_aux_read;
      (i_rd && i_addr == A_AUX) |=> o_rdata[B_AUX_XO] == $past(o_crossed);
   endproperty
   a_aux_read: assert property (p_aux_read) else $error("aux status wrong");
   property p_ds_exit;
      i_partner_gig |=> o_adv_gig;
   endproperty
   a_ds_exit: assert property (p_ds_exit) else $error("downshift kept");
   property p_pd_search;
      (q.pd_st == PD_RUN) |-> o_pd_flp_send && q.pd_res == PD_SRCH && !o_autoneg_run;
   endproperty
   a_pd_search: assert property (p_pd_search) else $error("search state wrong");
   property p_pd_loop;
      (q.pd_st == PD_RUN && q.lb_f) |=> q.pd_res == PD_LOOP;
   endproperty
   a_pd_loop: assert property (p_pd_loop) else $error("loop not reported");
   property p_pd_tmo;
      (q.pd_st == PD_RUN && !q.lb_f && q.pd_tmr == '0 && !i_wr)
         |=> q.pd_res == PD_NONE && !q.pd_en && o_autoneg_run == q.ctrl[B_ANEG];
   endproperty
   a_pd_tmo: assert property (p_pd_tmo) else $error("timeout wrong");
   property p_pd_again;
      (q.pd_st == PD_NORMAL && q.link_f && !q.link_s[2] && !q.link_s[1] && !i_wr) |=> o_pd_flp_send;
   endproperty
   a_pd_again: assert property (p_pd_again) else $error("no redetect");
   property p_wake;
      (mp_hit && q.wake_msk && !i_wr) |=> o_wake ##1 (o_wake || $past(i_rd));
   endproperty
   a_wake: assert property (p_wake) else $error("wake not raised");

   c_downshift: cover property ($rose(q.ds_stat));
   c_pd_loop:   cover property (q.pd_st == PD_RUN ##1 q.pd_st == PD_POWER);
   c_pd_none:   cover property (q.pd_st == PD_RUN ##1 q.pd_st == PD_NORMAL);
   c_wake:      cover property ($rose(o_wake));
endmodule : cpl_link_features
`default_nettype wire

//--- dv/cpl_partner.sv
// Purpose: Cable-side link partner for the copper link feature bench
// Assumes: A powered device loops pulses back until power arrives
// Notes:   Link rises P_LINK_DLY cycles after contact, and after power for a powered device
`timescale 1ns/1ps
`default_nettype none
module cpl_partner #(
   parameter int P_LINK_DLY = 4
)(
   input  wire logic       i_clock,
   input  wire logic       i_plug,
   input  wire logic       i_is_pd,
   input  wire logic       i_power,
   input  wire logic       i_flp_send,
   input  wire logic [1:0] i_map,
   output logic            o_link_up,
   output logic            o_flp_looped = 1'h0,
   output logic            o_crossed,
   output logic            o_cd_swap
);
   int cnt_q = 0;
   // Unpowered device closes the loop only while pulses arrive
   always @(posedge i_clock) o_flp_looped <= i_is_pd & ~i_power & i_flp_send;
   // An unpowered device never links, so link waits for power
   always @(posedge i_clock)
   begin
      if (!i_plug || (i_is_pd && !i_power)) cnt_q <= 0;
      else if (cnt_q < P_LINK_DLY) cnt_q <= cnt_q + 1;
   end
   assign o_link_up = (cnt_q == P_LINK_DLY);
   // Bit 0 crosses A/B, bit 1 swaps C/D
   assign o_crossed = i_map[0];
   assign o_cd_swap = i_map[1];
endmodule : cpl_partner
`default_nettype wire

//--- dv/tb_copper_phy_link_features.sv
// Purpose: Self-checking bench for the copper link feature block
// Assumes: Detection wait shortened to P_WAIT cycles
// Notes:   Expected values are built here from integers and queues
`timescale 1ns/1ps
`default_nettype none
module tb_copper_phy_link_features
   import cpl_pkg::*;
;
   localparam int P_WAIT = 20;
   logic        i_clock = 1'h0, i_nrst = 1'h0, i_wr = 1'h0, i_rd = 1'h0;
   logic [4:0]  i_addr = 5'h00;
   logic [15:0] i_wdata = 16'h0000, o_rdata, v;
   logic [1:0]  i_an_speed = 2'h0, map = 2'h0, o_speed;
   logic [3:0]  i_pol_inverted = 4'h0, o_pol_fix;
   logic [7:0]  i_rx_data = 8'h00;
   logic        i_an_duplex = 1'h0, i_gig_fail = 1'h0, i_partner_gig = 1'h0;
   logic        i_rx_start = 1'h0, i_rx_valid = 1'h0;
   logic        plug = 1'h1, is_pd = 1'h0, power = 1'h0;
   logic        i_link_up, i_flp_looped, i_mdi_crossed, i_mdi_cd_swap;
   logic        o_crossed, o_cd_swap, o_full_duplex, o_autoneg_run, o_adv_gig;
   logic        o_gig_test, o_lpi_allow, o_low_amp_ten, o_pd_flp_send, o_wake;
   logic [31:0] seed = 32'h6C5F;
   logic [47:0] mac, pwd;
   logic [7:0]  pkt[$];
   int          error_cnt = 0, check_count = 0;

   always #10 i_clock = ~i_clock;

   cpl_link_features #(.P_PD_WAIT_CYC(P_WAIT)) DUT (
      .i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_link_up(i_link_up),
      .i_an_speed(i_an_speed), .i_an_duplex(i_an_duplex), .i_mdi_crossed(i_mdi_crossed),
      .i_mdi_cd_swap(i_mdi_cd_swap), .i_pol_inverted(i_pol_inverted), .i_gig_fail(i_gig_fail),
      .i_partner_gig(i_partner_gig), .i_flp_looped(i_flp_looped), .i_rx_start(i_rx_start),
      .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .o_crossed(o_crossed),
      .o_cd_swap(o_cd_swap), .o_pol_fix(o_pol_fix), .o_speed(o_speed),
      .o_full_duplex(o_full_duplex), .o_autoneg_run(o_autoneg_run), .o_adv_gig(o_adv_gig),
      .o_gig_test(o_gig_test), .o_lpi_allow(o_lpi_allow), .o_low_amp_ten(o_low_amp_ten),
      .o_pd_flp_send(o_pd_flp_send), .o_wake(o_wake));

   cpl_partner u_partner (
      .i_clock(i_clock), .i_plug(plug), .i_is_pd(is_pd), .i_power(power),
      .i_flp_send(o_pd_flp_send), .i_map(map), .o_link_up(i_link_up),
      .o_flp_looped(i_flp_looped), .o_crossed(i_mdi_crossed), .o_cd_swap(i_mdi_cd_swap));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask : cyc

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge i_clock);
      i_wr    <= 1'h1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr <= 1'h0;
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge i_clock);
      i_rd   <= 1'h1;
      i_addr <= a;
      @(posedge i_clock);
      i_rd <= 1'h0;
      #1 d = o_rdata;
   endtask : rd

   task automatic send(input logic [7:0] q[$]);
      @(posedge i_clock);
      i_rx_start <= 1'h1;
      @(posedge i_clock);
      i_rx_start <= 1'h0;
      foreach (q[i])
      begin
         i_rx_valid <= 1'h1;
         i_rx_data  <= q[i];
         @(posedge i_clock);
      end
      i_rx_valid <= 1'h0;
   endtask : send

   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish

   // Watchdog sized well beyond the few hundred cycles the tests need
   initial
   begin
      #(20 * 20000);
      error_cnt++;
      tally_and_finish();
   end

   initial
   begin
      repeat (4) @(posedge i_clock);
      i_nrst <= 1'h1;
      cyc(8);
      // Reset values and an unmapped read
      rd(A_CTRL, v); chk(v, R_CTRL);
      rd(A_BYP, v); chk(v & 16'h00B0, 16'h0000);
      rd(A_EXT3, v); chk(v & 16'h0010, 16'h0010);
      rd(5'h1F, v); chk(v, 16'h0000);
      rd(A_STAT, v); chk(v, 16'h0004);
      chk(16'(o_lpi_allow), 16'h0000);
      $display("test reset done");
      // Every pair mapping with random per-pair inversion
      for (int m = 0; m < 4; m++)
      begin
         @(posedge i_clock);
         seed = lfsr(seed);
         map <= m[1:0];
         i_pol_inverted <= seed[3:0];
         cyc(3);
         chk({14'h0, o_cd_swap, o_crossed}, 16'(m));
         chk(16'(o_pol_fix), 16'(seed[3:0]));
         rd(A_AUX, v); chk(v & 16'h3F00, {2'h0, m[0], m[1], seed[3:0], 8'h00});
      end
      map <= 2'h1;
      wr(A_EXTM, 16'h0008); cyc(2); chk(16'(o_crossed), 16'h0000);
      map <= 2'h0;
      wr(A_EXTM, 16'h000C); cyc(2); chk(16'(o_crossed), 16'h0001);
      map <= 2'h1;
      wr(A_EXTM, 16'h0000); wr(A_BYP, 16'h0030); cyc(2);
      chk({11'h0, o_pol_fix, o_crossed}, 16'h0000);
      $display("test crossover done");
      // Forced speeds, energy options and gigabit test mode
      wr(A_BYP, 16'h0000); wr(A_CTRL, 16'h2100); cyc(3);
      chk({12'h0, o_speed, o_full_duplex, o_crossed}, {12'h0, SPD_100, 2'h3});
      chk(16'(o_lpi_allow), 16'h0001);
      wr(A_BYP, 16'h0080); cyc(2); chk(16'(o_crossed), 16'h0000);
      wr(A_CTRL, 16'h0000); wr(A_EEE, 16'h0011); cyc(2);
      chk({12'h0, o_speed, o_lpi_allow, o_low_amp_ten}, 16'h0001);
      wr(A_EEE, 16'h0021); wr(A_CTRL, 16'h0140); cyc(2);
      chk({13'h0, o_speed, o_gig_test}, {13'h0, SPD_1000, 1'h1});
      wr(A_EEE, 16'h0001); wr(A_CTRL, R_CTRL);
      $display("test forced modes done");
      // Downshift after cfg+2 failed attempts, cleared by a gigabit partner
      i_an_speed <= SPD_1000;
      i_an_duplex <= 1'h1;
      wr(A_EXT3, 16'h0014); cyc(2);
      chk({13'h0, o_speed, o_full_duplex}, {13'h0, SPD_1000, 1'h1});
      for (int k = 1; k <= 3; k++)
      begin
         @(posedge i_clock) i_gig_fail <= 1'h1;
         @(posedge i_clock) i_gig_fail <= 1'h0;
         cyc(1);
         chk(16'(o_adv_gig), 16'(k < 3));
      end
      rd(A_EXT3, v); chk(v & 16'h0002, 16'h0002);
      @(posedge i_clock) i_partner_gig <= 1'h1;
      @(posedge i_clock) i_partner_gig <= 1'h0;
      cyc(1); chk(16'(o_adv_gig), 16'h0001);
      $display("test downshift done");
      // Magic packet: mask off, mask on, then mask on behind a password
      seed = lfsr(seed);
      mac = {8'h02, seed[7:0], seed[15:8], seed[23:16], seed[31:24], seed[11:4]};
      wr(A_MAC0, mac[47:32]); wr(A_MAC1, mac[31:16]); wr(A_MAC2, mac[15:0]);
      repeat (6) pkt.push_back(8'hFF);
      repeat (16) for (int b = 0; b < 6; b++) pkt.push_back(mac[47 - 8 * b -: 8]);
      pwd = {mac[23:0], mac[47:24]};
      for (int msk = 0; msk < 3; msk++)
      begin
         if (msk == 2)
         begin
            // Password mode: the wake needs six more matching bytes
            wr(A_WCFG, 16'h0020); wr(A_PWD0, pwd[47:32]);
            wr(A_PWD1, pwd[31:16]); wr(A_PWD2, pwd[15:0]);
            for (int b = 0; b < 6; b++) pkt.push_back(pwd[47 - 8 * b -: 8]);
         end
         wr(A_IMSK, msk ? 16'h0040 : 16'h0000);
         send(pkt); cyc(1);
         chk(16'(o_wake), 16'(msk != 0));
         rd(A_ISTA, v); chk(v & 16'h0040, msk ? 16'h0040 : 16'h0000);
         chk(16'(o_wake), 16'h0000);
      end
      $display("test wake done");
      // Powered device search, loop, power, link loss, then timeout
      plug <= 1'h0;
      wr(A_EXT4, 16'h8000); cyc(1);
      chk({14'h0, o_pd_flp_send, o_autoneg_run}, 16'h0002);
      rd(A_EXT4, v); chk(v & 16'hE000, 16'h8000);
      is_pd <= 1'h1;
      cyc(6); rd(A_EXT4, v); chk(v & 16'h6000, 16'h2000);
      power <= 1'h1;
      plug <= 1'h1;
      cyc(12);
      plug <= 1'h0;
      power <= 1'h0;
      is_pd <= 1'h0;
      cyc(7); chk(16'(o_pd_flp_send), 16'h0001);
      rd(A_STAT, v); chk(v, 16'h0000);
      rd(A_EXT4, v); chk(v & 16'hE000, 16'h8000);
      cyc(P_WAIT + 4); rd(A_EXT4, v); chk(v & 16'hE000, 16'h4000);
      chk({14'h0, o_pd_flp_send, o_autoneg_run}, 16'h0001);
      $display("test inline power done");
      tally_and_finish();
   end
endmodule : tb_copper_phy_link_features
`default_nettype wire
